// ---- dv/core_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// core side: offers a word, holds it while refused, scrambles released data
module core_src import oreg_pkg::*; (
  input  wire logic      core_clk,
  input  wire logic      send,
  input  wire out_word_s word,
  input  wire logic      in_ready,
  output var logic       in_valid = 1'h0,
  output var out_word_s  in_word = '0
);
  always @(posedge core_clk) begin
    if (in_ready || !in_valid) begin
      in_valid <= send;
      in_word <= send ? word : ~in_word;
    end
  end
endmodule
`default_nettype wire

// ---- dv/io_output_ddr_register_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module io_output_ddr_register_bench import oreg_pkg::*; ;
  logic core_clk = 1'h0, rst_n = 1'h1, clk_en = 1'h1, send = 1'h0;
  logic in_valid, in_ready, pad_out, pad_oe;
  out_mode_e mode = MODE_SDR_FF;
  out_word_s word = '0, in_word;
  int n_fail = 0, n_checks = 0;
  always #2 core_clk = ~core_clk;
  io_output_ddr_register dut (.core_clk, .rst_n, .clk_en, .mode, .in_valid, .in_ready,
    .in_word, .pad_out, .pad_oe);
  core_src src (.core_clk, .send, .word, .in_ready, .in_valid, .in_word);
  // offer one word for one cycle in the given mode
  task automatic put(input out_mode_e m, input logic en, input out_word_s w);
    @(posedge core_clk) #1;
    mode = m;
    clk_en = en;
    send = 1'h1;
    word = w;
    @(posedge core_clk) #1;
    send = 1'h0;
  endtask
  // pad after the stage loads: high phase, then low phase
  task automatic look(input logic hi, input logic lo, input logic oe);
    @(posedge core_clk);
    @(posedge core_clk) #1;
    `CHK(pad_oe, oe)
    `CHK(pad_out, hi)
    `CHK(in_ready, 1'h1)
    @(negedge core_clk) #1;
    `CHK(pad_out, lo)
  endtask
  task automatic t_sdr();
    put(MODE_SDR_FF, 1'h1, 3'h5);
    look(1'h1, 1'h1, 1'h1);
    put(MODE_SDR_FF, 1'h0, 3'h2);
    look(1'h1, 1'h1, 1'h1);
  endtask
  task automatic t_latch();
    put(MODE_SDR_LATCH, 1'h1, 3'h2);
    look(1'h0, 1'h0, 1'h0);
  endtask
  task automatic t_ddr();
    put(MODE_DDR, 1'h1, 3'h4);
    look(1'h1, 1'h0, 1'h0);
    put(MODE_DDR, 1'h1, 3'h3);
    look(1'h0, 1'h1, 1'h1);
  endtask
  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #1;
    rst_n = 1'h0;
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'h1;
    t_sdr();
    t_latch();
    t_ddr();
    summarize();
  end
  // watchdog
  initial begin
    #2000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire

// ---- dv/io_output_ddr_register_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module oreg_chk import oreg_pkg::*; (
  input wire logic      core_clk,
  input wire logic      rst_n,
  input wire logic      clk_en,
  input wire out_mode_e mode,
  input wire logic      in_valid,
  input wire logic      in_ready,
  input wire out_word_s in_word,
  input wire logic      pad_out,
  input wire logic      pad_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // word taken, then one more enabled edge loads the stage
  // word pushed into the buffer
  sequence s_push;
    clk_en && in_valid && in_ready;
  endsequence
  sequence s_sent;
    clk_en && in_valid && in_ready ##1 clk_en;
  endsequence
  a_oe_follows: assert property (s_sent |=> pad_oe == $past(in_word.tristate, 2))
    else $error("oe wrong");
  a_oe_frozen: assert property (!clk_en |=> $stable(pad_oe))
    else $error("oe moved");
  a_sdr_ff: assert property ((s_sent ##1 mode == MODE_SDR_FF) |->
    pad_out == $past(in_word.first, 2)) else $error("sdr out");
  a_sdr_latch: assert property ((s_push ##1 (clk_en && mode == MODE_SDR_LATCH)) |->
    pad_out == $past(in_word.first)) else $error("latch out");
  a_ddr_fall: assert property ((s_sent ##1 mode == MODE_DDR && clk_en) |->
    pad_out == $past(in_word.second, 2)) else $error("ddr low");
  a_ddr_rise: assert property (@(negedge core_clk) (s_sent ##1 mode == MODE_DDR) |->
    pad_out == $past(in_word.first, 2)) else $error("ddr high");
  a_ff_frozen: assert property ((!clk_en && mode == MODE_SDR_FF) |=> $stable(pad_out))
    else $error("out moved");
  a_reset_idle: assert property (disable iff (1'h0) !rst_n |-> !pad_out && !pad_oe && in_ready)
    else $error("reset state");
endmodule
bind io_output_ddr_register oreg_chk chk (.core_clk, .rst_n, .clk_en, .mode, .in_valid,
  .in_ready, .in_word, .pad_out, .pad_oe);
`default_nettype wire

// ---- logic/io_output_ddr_register.sv ----
// Functional notes
// (R1) core output signals pass a register stage before reaching the pad buffer
// (R2) single-rate mode: first data goes through one storage element to the pad
// (R3) single-rate storage element selectable as flip-flop or transparent latch
// (R4) double-rate mode: both data inputs sampled on each rising edge
// (R5) second data rising sample moved to a falling-edge register
// (R6) output mux on the same clock alternates rise and fall registers
// (R7) output-enable registered in a single-rate flip-flop driving tri-state control
// (R8) mux shows rise register while clock high, fall register while low
`timescale 1ns/1ps
`default_nettype none
module io_output_ddr_register
  import oreg_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic      clk_en,
  input  wire out_mode_e mode,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire out_word_s in_word,
  output logic           pad_out,
  output logic           pad_oe
);
  out_word_s word;
  logic      word_valid;
  logic      rise_stage_reg;
  logic      second_stage;
  logic      fall_stage_reg;
  logic      tri_stage;
  logic      latch_stage;
  logic      next_rise;
  logic      next_second;
  logic      next_fall;
  logic      next_tri;
  logic      take;

  // elastic buffer between core fabric and the cell
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_word),
    .out_valid (word_valid),
    .out_ready (1'b1),
    .out_data  (word)
  );

  // hold last value when no word is available
  always_comb begin
    take        = clk_en && word_valid;
    next_rise   = take ? word.first : rise_stage_reg;   // R1 R2 R4
    next_second = take ? word.second : second_stage;    // R4
    next_tri    = take ? word.tristate : tri_stage;     // R7
    next_fall   = clk_en ? second_stage : fall_stage_reg; // R5
  end

  // rising-edge capture stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_stage_reg <= RISE_RESET;
      second_stage   <= RISE_RESET;
      tri_stage      <= TRI_RESET;
    end else begin
      rise_stage_reg <= next_rise;
      second_stage   <= next_second;
      tri_stage      <= next_tri;
    end
  end

  // falling-edge retime of second data
  always_ff @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_stage_reg <= FALL_RESET;
    end else begin
      fall_stage_reg <= next_fall; // R5
    end
  end

  // latch variant: transparent while clock high, clock enabled and data available
  always_latch begin
    if (!rst_n) begin
      latch_stage = RISE_RESET;
    end else if (core_clk && take) begin
      latch_stage = word.first; // R3
    end
  end

  // pad output selection
  always_comb begin
    unique case (mode)
      MODE_SDR_FF:    pad_out = rise_stage_reg; // R2 R3
      MODE_SDR_LATCH: pad_out = latch_stage;    // R3
      MODE_DDR:       pad_out = core_clk ? rise_stage_reg : fall_stage_reg; // R6 R8
      default:        pad_out = rise_stage_reg;
    endcase
    pad_oe = tri_stage; // R7
  end
endmodule
`default_nettype wire

// ---- logic/oreg_pkg.sv ----
package oreg_pkg;
  // output mode selection
  typedef enum logic [1:0] {
    MODE_SDR_FF,
    MODE_SDR_LATCH,
    MODE_DDR
  } out_mode_e;

  // one word of core output data with its tri-state control
  typedef struct packed {
    logic first;
    logic second;
    logic tristate;
  } out_word_s;

  localparam int        FIFO_DEPTH      = 16;
  localparam int        WORD_W          = 3;
  localparam logic      RISE_RESET      = 1'b0;
  localparam logic      FALL_RESET      = 1'b0;
  localparam logic      TRI_RESET       = 1'b0;
endpackage

// ---- logic/word_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // pointer and occupancy update
  always_comb begin
    push        = clk_en && in_valid && in_ready;
    pop         = clk_en && out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire
